// ### common/haw_pkg.sv
`default_nettype none
package haw_pkg;
  // register indices; byte address is four times the index
  localparam logic [9:0]  PRESC_IDX      = 10'h049;
  localparam logic [9:0]  CSR_IDX        = 10'h04A;
  localparam logic [9:0]  IRQ_STAT_IDX   = 10'h04B;
  localparam logic [9:0]  IRQ_MASK_IDX   = 10'h04C;
  localparam int          ADDR_W         = 12;
  // reset values
  localparam logic [7:0]  PRESC_RST      = 8'hFF;
  localparam logic [2:0]  CSR_RST        = 3'h0;
  localparam logic [2:0]  IRQ_RST        = 3'h0;
  // control/status field positions
  localparam int          CSR_EN_BIT     = 0;
  localparam int          CSR_MEAS_BIT   = 1;
  localparam int          CSR_FLAG_BIT   = 2;
  // interrupt status field positions
  localparam int          IRQ_EXPIRE_BIT = 0;
  localparam int          IRQ_EXIT_BIT   = 1;
  localparam int          IRQ_RESUME_BIT = 2;
  localparam int          IRQ_W          = 3;
  // wake oscillator divider and start-up, in wake oscillator ticks
  localparam int          DIV_W          = 6;
  localparam logic [5:0]  DIV_LAST       = 6'h3F;
  localparam logic [2:0]  OSC_START_TICKS = 3'h4;
  // main oscillator stabilisation, in cpu cycles
  localparam logic [9:0]  STAB_SHORT     = 10'h100;
  localparam logic [9:0]  STAB_LONG      = 10'h200;
  localparam logic [1:0]  HTRANS_NONSEQ  = 2'h2;
  typedef enum logic [1:0] {ST_RUN, ST_HALT, ST_STAB} haw_state_t;
endpackage
`default_nettype wire

// ### rtl/haw_wake_counter.sv
`timescale 1ns/100ps
`default_nettype none
module haw_wake_counter #(
  parameter bit ZERO_FIRES = 1'b1
) (
  input  wire logic       clk,        // system clock
  input  wire logic       rst_n,      // async reset, active low
  input  wire logic       run,        // halt with autowake enabled
  input  wire logic       tick,       // wake oscillator tick
  input  wire logic [7:0] presc,      // dividing factor
  output logic            expire      // one-cycle pulse at end of delay
);
  logic [2:0] start_reg, start_next;
  logic [5:0] div_reg,   div_next;
  logic [7:0] pre_reg,   pre_next;
  logic       fired_reg, fired_next;
  logic       exp_reg,   exp_next;

  always_comb begin
    start_next = start_reg;
    div_next   = div_reg;
    pre_next   = pre_reg;
    fired_next = fired_reg;
    exp_next   = 1'b0;
    if (!run) begin
      start_next = 3'h0;
      div_next   = 6'h00;
      pre_next   = 8'h00;
      fired_next = 1'b0;
    end else if (fired_reg) begin
      fired_next = 1'b1;
    end else if (presc == 8'h00 && ZERO_FIRES) begin
      exp_next   = 1'b1;
      fired_next = 1'b1;
    end else if (tick) begin
      if (start_reg != haw_pkg::OSC_START_TICKS) begin
        start_next = start_reg + 3'h1;
      end else if (div_reg != haw_pkg::DIV_LAST) begin
        div_next = div_reg + 6'h01;
      end else begin
        div_next = 6'h00;
        pre_next = pre_reg + 8'h01;
        if (pre_next == presc) begin
          exp_next   = 1'b1;
          fired_next = 1'b1;
        end
      end
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      start_reg <= 3'h0;
      div_reg   <= 6'h00;
      pre_reg   <= 8'h00;
      fired_reg <= 1'b0;
      exp_reg   <= 1'b0;
    end else begin
      start_reg <= start_next;
      div_reg   <= div_next;
      pre_reg   <= pre_next;
      fired_reg <= fired_next;
      exp_reg   <= exp_next;
    end
  end

  assign expire = exp_reg;

  only_in_run_a: assert property (@(posedge clk) disable iff (!rst_n)
    expire |-> $past(run)) else $error("expire outside halt");
endmodule
`default_nettype wire

// ### rtl/haw_autowake.sv
`timescale 1ns/100ps
`default_nettype none
module haw_autowake #(
  parameter bit ZERO_FIRES = 1'b1
) (
  input  wire logic        hclk,                 // system clock, 25 MHz
  input  wire logic        hresetn,              // async reset, active low
  input  wire logic        hsel,                 // slave select
  input  wire logic [31:0] haddr,                // byte address
  input  wire logic [1:0]  htrans,               // transfer type
  input  wire logic        hwrite,               // write when high
  input  wire logic [2:0]  hsize,                // transfer size
  input  wire logic [31:0] hwdata,               // write data
  input  wire logic        hready,               // bus ready
  output logic             hreadyout,            // slave ready
  output logic [31:0]      hrdata,               // read data
  output logic             hresp,                // always okay
  input  wire logic        halt_exec,            // halt instruction executed, pulse
  input  wire logic        exit_irq,             // interrupt able to leave halt
  input  wire logic        wdg_active,           // watchdog running
  input  wire logic        watchdog_halt_option, // 1: halt allowed with watchdog
  input  wire logic        stab_long_sel,        // 1: 512-cycle stabilisation
  input  wire logic        wake_osc_tick,        // wake oscillator tick
  output logic             wake_osc_en,          // wake oscillator enable
  output logic             main_osc_en,          // main oscillator enable
  output logic             halt_autowake_mode,   // in autowake halt
  output logic             periph_clk_en,        // peripheral clocks running
  output logic             imask_force_clear,    // clear interrupt mask, pulse
  output logic             autowake_irq,         // pending wake interrupt
  output logic             cpu_resume,           // stabilisation done, pulse
  output logic             lt_capture_in,        // wake clock to capture input
  output logic             wdg_reset_req,        // watchdog reset, pulse
  output logic             irq                   // masked status interrupt
);
  //////////////////////////////////////////////////////////////////////////////
  // bus slave
  logic       dp_valid_reg, dp_valid_next;
  logic       dp_write_reg, dp_write_next;
  logic [9:0] dp_idx_reg,   dp_idx_next;
  logic       dp_hit_reg,   dp_hit_next;
  logic       rd_wait_reg,  rd_wait_next;
  logic [31:0] hrdata_reg,  hrdata_next;
  logic       addr_phase;
  logic       addr_hit;
  logic       wr_en;
  logic       rd_load;
  logic [31:0] rd_mux;

  assign addr_phase = hsel && hready && (htrans == haw_pkg::HTRANS_NONSEQ);
  assign addr_hit   = (haddr[31:haw_pkg::ADDR_W] == '0) && (haddr[1:0] == 2'h0);
  assign wr_en      = dp_valid_reg && dp_write_reg && dp_hit_reg;
  assign rd_load    = dp_valid_reg && !dp_write_reg && !rd_wait_reg;

  always_comb begin
    dp_valid_next = 1'b0;
    dp_write_next = dp_write_reg;
    dp_idx_next   = dp_idx_reg;
    dp_hit_next   = dp_hit_reg;
    rd_wait_next  = 1'b0;
    hrdata_next   = hrdata_reg;
    if (dp_valid_reg && !dp_write_reg && !rd_wait_reg) begin
      dp_valid_next = 1'b1;
      rd_wait_next  = 1'b1;
      hrdata_next   = dp_hit_reg ? rd_mux : 32'h0000_0000;
    end else if (addr_phase) begin
      dp_valid_next = 1'b1;
      dp_write_next = hwrite;
      dp_idx_next   = haddr[11:2];
      dp_hit_next   = addr_hit;
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      dp_valid_reg <= 1'b0;
      dp_write_reg <= 1'b0;
      dp_idx_reg   <= 10'h000;
      dp_hit_reg   <= 1'b0;
      rd_wait_reg  <= 1'b0;
      hrdata_reg   <= 32'h0000_0000;
    end else begin
      dp_valid_reg <= dp_valid_next;
      dp_write_reg <= dp_write_next;
      dp_idx_reg   <= dp_idx_next;
      dp_hit_reg   <= dp_hit_next;
      rd_wait_reg  <= rd_wait_next;
      hrdata_reg   <= hrdata_next;
    end
  end

  // reads take one wait state so the returned word and read-clear agree
  assign hreadyout = !(dp_valid_reg && !dp_write_reg && !rd_wait_reg);
  assign hrdata    = hrdata_reg;
  assign hresp     = 1'b0;

  //////////////////////////////////////////////////////////////////////////////
  // registers
  logic [7:0]  presc_reg,  presc_next;
  logic        en_reg,     en_next;
  logic        meas_reg,   meas_next;
  logic        flag_reg,   flag_next;
  logic [2:0]  stat_reg,   stat_next;
  logic [2:0]  mask_reg,   mask_next;
  logic        expire;
  logic        csr_rd;
  logic [2:0]  events;

  assign csr_rd = rd_load && dp_hit_reg && (dp_idx_reg == haw_pkg::CSR_IDX);

  always_comb begin
    rd_mux = 32'h0000_0000;
    case (dp_idx_reg)
      haw_pkg::PRESC_IDX:    rd_mux = {24'h000000, presc_reg};
      haw_pkg::CSR_IDX:      rd_mux = {29'h0, flag_reg, meas_reg, en_reg};
      haw_pkg::IRQ_STAT_IDX: rd_mux = {29'h0, stat_reg};
      haw_pkg::IRQ_MASK_IDX: rd_mux = {29'h0, mask_reg};
      default:               rd_mux = 32'h0000_0000;
    endcase
  end

  always_comb begin
    presc_next = presc_reg;
    en_next    = en_reg;
    meas_next  = meas_reg;
    flag_next  = flag_reg;
    stat_next  = stat_reg;
    mask_next  = mask_reg;
    if (wr_en) begin
      case (dp_idx_reg)
        haw_pkg::PRESC_IDX: begin
          if (hwdata[7:0] != 8'h00 || ZERO_FIRES) begin
            presc_next = hwdata[7:0];
          end
        end
        haw_pkg::CSR_IDX: begin
          en_next   = hwdata[haw_pkg::CSR_EN_BIT];
          meas_next = hwdata[haw_pkg::CSR_MEAS_BIT];
        end
        haw_pkg::IRQ_STAT_IDX: stat_next = stat_reg & ~hwdata[2:0];
        haw_pkg::IRQ_MASK_IDX: mask_next = hwdata[2:0];
        default: ;
      endcase
    end
    if (csr_rd) begin
      flag_next = 1'b0;
    end
    if (expire) begin
      flag_next = 1'b1;
    end
    stat_next = stat_next | events;
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      presc_reg <= haw_pkg::PRESC_RST;
      en_reg    <= haw_pkg::CSR_RST[haw_pkg::CSR_EN_BIT];
      meas_reg  <= haw_pkg::CSR_RST[haw_pkg::CSR_MEAS_BIT];
      flag_reg  <= haw_pkg::CSR_RST[haw_pkg::CSR_FLAG_BIT];
      stat_reg  <= haw_pkg::IRQ_RST;
      mask_reg  <= haw_pkg::IRQ_RST;
    end else begin
      presc_reg <= presc_next;
      en_reg    <= en_next;
      meas_reg  <= meas_next;
      flag_reg  <= flag_next;
      stat_reg  <= stat_next;
      mask_reg  <= mask_next;
    end
  end

  assign autowake_irq = flag_reg;

  //////////////////////////////////////////////////////////////////////////////
  // power-mode sequencer
  haw_pkg::haw_state_t state_reg, state_next;
  logic [9:0] stab_cnt_reg,  stab_cnt_next;
  logic       stab_long_reg, stab_long_next;
  logic       resume_reg,    resume_next;
  logic       imask_reg,     imask_next;
  logic       wdg_reg,       wdg_next;
  logic       cap_reg,       cap_next;
  logic       irq_reg,       irq_next;
  logic       exit_ev;
  logic       wdg_block;
  logic [9:0] stab_target;

  assign wdg_block   = wdg_active && !watchdog_halt_option;
  assign stab_target = stab_long_reg ? haw_pkg::STAB_LONG : haw_pkg::STAB_SHORT;

  always_comb begin
    state_next     = state_reg;
    stab_cnt_next  = stab_cnt_reg;
    stab_long_next = stab_long_reg;
    resume_next    = 1'b0;
    imask_next     = 1'b0;
    wdg_next       = 1'b0;
    exit_ev        = 1'b0;
    case (state_reg)
      haw_pkg::ST_RUN: begin
        if (halt_exec && wdg_block) begin
          wdg_next = 1'b1;
        end else if (halt_exec) begin
          state_next = haw_pkg::ST_HALT;
          imask_next = 1'b1;
        end
      end
      haw_pkg::ST_HALT: begin
        if (expire || exit_irq) begin
          state_next     = haw_pkg::ST_STAB;
          stab_cnt_next  = 10'h000;
          stab_long_next = stab_long_sel;
          exit_ev        = !expire;
        end
      end
      haw_pkg::ST_STAB: begin
        stab_cnt_next = stab_cnt_reg + 10'h001;
        if (stab_cnt_reg == stab_target - 10'h001) begin
          state_next  = haw_pkg::ST_RUN;
          resume_next = 1'b1;
        end
      end
      default: state_next = haw_pkg::ST_RUN;
    endcase
    cap_next = (state_reg == haw_pkg::ST_RUN) && meas_reg && wake_osc_tick;
    irq_next = |(stat_reg & mask_reg);
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      state_reg     <= haw_pkg::ST_RUN;
      stab_cnt_reg  <= 10'h000;
      stab_long_reg <= 1'b0;
      resume_reg    <= 1'b0;
      imask_reg     <= 1'b0;
      wdg_reg       <= 1'b0;
      cap_reg       <= 1'b0;
      irq_reg       <= 1'b0;
    end else begin
      state_reg     <= state_next;
      stab_cnt_reg  <= stab_cnt_next;
      stab_long_reg <= stab_long_next;
      resume_reg    <= resume_next;
      imask_reg     <= imask_next;
      wdg_reg       <= wdg_next;
      cap_reg       <= cap_next;
      irq_reg       <= irq_next;
    end
  end

  assign events[haw_pkg::IRQ_EXPIRE_BIT] = expire;
  assign events[haw_pkg::IRQ_EXIT_BIT]   = exit_ev;
  assign events[haw_pkg::IRQ_RESUME_BIT] = resume_reg;

  haw_wake_counter #(
    .ZERO_FIRES (ZERO_FIRES)
  ) u_counter (
    .clk    (hclk),
    .rst_n  (hresetn),
    .run    ((state_reg == haw_pkg::ST_HALT) && en_reg),
    .tick   (wake_osc_tick),
    .presc  (presc_reg),
    .expire (expire)
  );

  // main oscillator and peripherals stop for the whole halt
  assign main_osc_en        = (state_reg != haw_pkg::ST_HALT);
  assign periph_clk_en      = (state_reg == haw_pkg::ST_RUN);
  assign halt_autowake_mode = (state_reg == haw_pkg::ST_HALT) && en_reg;
  assign wake_osc_en        = halt_autowake_mode ||
                              ((state_reg == haw_pkg::ST_RUN) && meas_reg);
  assign imask_force_clear  = imask_reg;
  assign cpu_resume         = resume_reg;
  assign wdg_reset_req      = wdg_reg;
  assign lt_capture_in      = cap_reg;
  assign irq                = irq_reg;

  //////////////////////////////////////////////////////////////////////////////
  // checks
  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);

  flag_set_a: assert property (expire |=> flag_reg && autowake_irq)
    else $error("flag not set after expiry");
  read_clear_a: assert property (csr_rd && !expire |=> !flag_reg)
    else $error("csr read did not clear flag");
  flag_write_a: assert property (wr_en && !csr_rd && !expire |=> $stable(flag_reg))
    else $error("write changed flag");
  halt_entry_a: assert property (
    state_reg == haw_pkg::ST_RUN && halt_exec && !wdg_block
    |=> state_reg == haw_pkg::ST_HALT && imask_force_clear)
    else $error("halt entry wrong");
  wdg_block_a: assert property (
    state_reg == haw_pkg::ST_RUN && halt_exec && wdg_block
    |=> wdg_reset_req && state_reg == haw_pkg::ST_RUN)
    else $error("watchdog option ignored");
  stab_short_a: assert property (
    $rose(state_reg == haw_pkg::ST_STAB) && !stab_long_reg |-> ##256 cpu_resume)
    else $error("short stabilisation length wrong");
  halt_clock_a: assert property (
    state_reg == haw_pkg::ST_HALT |-> !main_osc_en && !periph_clk_en)
    else $error("clocks running in halt");
  meas_route_a: assert property (
    state_reg == haw_pkg::ST_RUN && meas_reg && wake_osc_tick |-> wake_osc_en ##1 lt_capture_in)
    else $error("measurement routing wrong");
  exit_irq_a: assert property (
    state_reg == haw_pkg::ST_HALT && exit_irq |=> state_reg == haw_pkg::ST_STAB)
    else $error("halt exit interrupt ignored");
  csr_reserved_a: assert property (
    csr_rd |=> hrdata[31:3] == 29'h0)
    else $error("reserved bits nonzero");

  auto_wake_c: cover property (expire ##[1:600] cpu_resume);
  irq_wake_c:  cover property (state_reg == haw_pkg::ST_HALT && exit_irq && !expire);
  long_stab_c: cover property ($rose(state_reg == haw_pkg::ST_STAB) && stab_long_sel);
endmodule
`default_nettype wire

// ### sim/haw_cpu_model.sv
`timescale 1ns/100ps
`default_nettype none
module haw_cpu_model #(
  parameter int TICK_DIV = 4
) (
  input  wire logic hclk,          // system clock
  input  wire logic hresetn,       // async reset, active low
  input  wire logic halt_cmd,      // bench asks for a halt
  input  wire logic wake_osc_en,   // wake oscillator enable
  output logic      halt_exec,     // halt executed, pulse
  output logic      wake_osc_tick  // wake oscillator tick
);
  logic [7:0] cnt_reg;
  logic       slow_reg;
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      cnt_reg       <= 8'h00;
      slow_reg      <= 1'b0;
      halt_exec     <= 1'b0;
      wake_osc_tick <= 1'b0;
    end else begin
      // cpu clock is moved to the slow source before any halt
      slow_reg      <= 1'b1;
      halt_exec     <= halt_cmd & slow_reg;
      // oscillator stands still while disabled
      if (wake_osc_en && cnt_reg != 8'(TICK_DIV - 1)) begin
        cnt_reg <= cnt_reg + 8'h01;
      end else begin
        cnt_reg <= 8'h00;
      end
      wake_osc_tick <= wake_osc_en && cnt_reg == 8'(TICK_DIV - 1);
    end
  end
endmodule
`default_nettype wire

// ### sim/tb_top.sv
`timescale 1ns/100ps
`default_nettype none
`define CHK(g, e) begin checks_done++; if ((g) !== (e)) begin n_fail++; \
  $display("MISMATCH t=%0t got=%h exp=%h", $time, (g), (e)); end end
module tb_top;
  localparam logic [31:0] A_PR = {20'h0, haw_pkg::PRESC_IDX, 2'h0};
  localparam logic [31:0] A_CS = {20'h0, haw_pkg::CSR_IDX, 2'h0};
  localparam logic [31:0] A_ST = {20'h0, haw_pkg::IRQ_STAT_IDX, 2'h0};
  localparam logic [31:0] A_MK = {20'h0, haw_pkg::IRQ_MASK_IDX, 2'h0};
  logic        hclk, hresetn, hsel, hwrite, hreadyout, hresp;
  logic [31:0] haddr, hwdata, hrdata, rd;
  logic [1:0]  htrans;
  logic [2:0]  hsize;
  wire logic   hready;
  logic        halt_cmd, halt_exec, exit_irq, wdg_active, watchdog_halt_option;
  logic        stab_long_sel, wake_osc_tick, wake_osc_en, main_osc_en;
  logic        halt_autowake_mode, periph_clk_en, imask_force_clear, autowake_irq;
  logic        cpu_resume, lt_capture_in, wdg_reset_req, irq;
  int          n_fail, checks_done;
  assign hready = hreadyout;

  haw_autowake dut (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hready),
    .hreadyout(hreadyout), .hrdata(hrdata), .hresp(hresp), .halt_exec(halt_exec),
    .exit_irq(exit_irq), .wdg_active(wdg_active), .watchdog_halt_option(watchdog_halt_option),
    .stab_long_sel(stab_long_sel), .wake_osc_tick(wake_osc_tick), .wake_osc_en(wake_osc_en),
    .main_osc_en(main_osc_en), .halt_autowake_mode(halt_autowake_mode),
    .periph_clk_en(periph_clk_en), .imask_force_clear(imask_force_clear),
    .autowake_irq(autowake_irq), .cpu_resume(cpu_resume), .lt_capture_in(lt_capture_in),
    .wdg_reset_req(wdg_reset_req), .irq(irq));
  haw_cpu_model cpu (.hclk(hclk), .hresetn(hresetn), .halt_cmd(halt_cmd),
    .wake_osc_en(wake_osc_en), .halt_exec(halt_exec), .wake_osc_tick(wake_osc_tick));

  ////////////////////////////////////////////////////////////////////////////////
  task automatic bus(input logic w, input logic [31:0] a, input logic [31:0] d);
    hsel <= 1'b1;
    htrans <= haw_pkg::HTRANS_NONSEQ;
    haddr <= a;
    hwrite <= w;
    @(posedge hclk);
    while (hready !== 1'b1) @(posedge hclk);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= w ? d : 32'h0;
    @(posedge hclk);
    while (hready !== 1'b1) @(posedge hclk);
    rd = hrdata;
  endtask
  task automatic rchk(input logic [31:0] a, input logic [31:0] e);
    bus(1'b0, a, 32'h0);
    `CHK(rd, e)
  endtask
  task automatic do_halt();
    halt_cmd <= 1'b1;
    @(posedge hclk);
    halt_cmd <= 1'b0;
    repeat (2) @(posedge hclk);
  endtask
  task automatic wait_resume();
    int n;
    n = 0;
    while (cpu_resume !== 1'b1 && n < 600) begin
      @(posedge hclk);
      n++;
    end
    `CHK(cpu_resume, 1'b1)
  endtask

  ////////////////////////////////////////////////////////////////////////////////
  task automatic t_regs();
    rchk(A_PR, 32'hFF);
    rchk(A_CS, 32'h0);
    rchk(A_ST, 32'h0);
    rchk(A_MK, 32'h0);
    bus(1'b1, 32'h200, 32'h55);
    rchk(32'h200, 32'h0);
    bus(1'b1, A_PR, 32'h5A);
    rchk(A_PR, 32'h5A);
    bus(1'b1, A_CS, 32'hFF);
    rchk(A_CS, 32'h3);
    bus(1'b1, A_CS, 32'h0);
    rchk(A_CS, 32'h0);
    `CHK(hresp, 1'b0)
    $display("test regs done");
  endtask
  task automatic aw_run(input logic [7:0] p, input logic lng);
    int ticks, n;
    ticks = 0;
    n = 0;
    stab_long_sel <= lng;
    bus(1'b1, A_PR, {24'h0, p});
    bus(1'b1, A_CS, 32'h1);
    do_halt();
    `CHK(main_osc_en, 1'b0)
    `CHK(periph_clk_en, 1'b0)
    `CHK(halt_autowake_mode, 1'b1)
    `CHK(wake_osc_en, 1'b1)
    `CHK(imask_force_clear, 1'b1)
    while (autowake_irq !== 1'b1 && n < 5000) begin
      if (wake_osc_tick === 1'b1) ticks++;
      @(posedge hclk);
      n++;
    end
    `CHK(ticks, int'(haw_pkg::OSC_START_TICKS) + 64 * int'(p))
    `CHK(main_osc_en, 1'b1)
    n = 0;
    while (cpu_resume !== 1'b1 && n < 600) begin
      @(posedge hclk);
      n++;
    end
    `CHK(n, int'(lng ? haw_pkg::STAB_LONG : haw_pkg::STAB_SHORT))
    `CHK(autowake_irq, 1'b1)
    `CHK(periph_clk_en, 1'b1)
    rchk(A_CS, 32'h5);
    rchk(A_CS, 32'h1);
    `CHK(autowake_irq, 1'b0)
    rchk(A_ST, 32'h5);
    bus(1'b1, A_ST, 32'h7);
  endtask
  task automatic t_wake();
    aw_run(8'h02, 1'b0);
    aw_run(8'h01, 1'b1);
    bus(1'b1, A_PR, 32'h0);
    rchk(A_PR, 32'h0);
    do_halt();
    repeat (2) @(posedge hclk);
    `CHK(autowake_irq, 1'b1)
    `CHK(main_osc_en, 1'b1)
    wait_resume();
    rchk(A_CS, 32'h5);
    bus(1'b1, A_ST, 32'h7);
    $display("test autowake done");
  endtask
  task automatic t_exit();
    bus(1'b1, A_PR, 32'hFF);
    bus(1'b1, A_CS, 32'h1);
    do_halt();
    repeat (20) @(posedge hclk);
    exit_irq <= 1'b1;
    @(posedge hclk);
    exit_irq <= 1'b0;
    @(posedge hclk);
    `CHK(main_osc_en, 1'b1)
    `CHK(halt_autowake_mode, 1'b0)
    wait_resume();
    rchk(A_ST, 32'h6);
    `CHK(irq, 1'b0)
    bus(1'b1, A_MK, 32'h2);
    repeat (2) @(posedge hclk);
    `CHK(irq, 1'b1)
    bus(1'b1, A_ST, 32'h6);
    repeat (2) @(posedge hclk);
    `CHK(irq, 1'b0)
    rchk(A_CS, 32'h1);
    bus(1'b1, A_MK, 32'h0);
    $display("test exit done");
  endtask
  task automatic t_wdg();
    wdg_active <= 1'b1;
    watchdog_halt_option <= 1'b0;
    bus(1'b1, A_CS, 32'h0);
    do_halt();
    `CHK(wdg_reset_req, 1'b1)
    `CHK(main_osc_en, 1'b1)
    watchdog_halt_option <= 1'b1;
    do_halt();
    `CHK(wdg_reset_req, 1'b0)
    `CHK(main_osc_en, 1'b0)
    `CHK(halt_autowake_mode, 1'b0)
    `CHK(wake_osc_en, 1'b0)
    exit_irq <= 1'b1;
    @(posedge hclk);
    exit_irq <= 1'b0;
    wait_resume();
    wdg_active <= 1'b0;
    bus(1'b1, A_ST, 32'h7);
    $display("test watchdog done");
  endtask
  task automatic t_meas();
    int n;
    n = 0;
    bus(1'b1, A_CS, 32'h2);
    @(posedge hclk);
    `CHK(wake_osc_en, 1'b1)
    while (wake_osc_tick !== 1'b1 && n < 50) begin
      @(posedge hclk);
      n++;
    end
    @(posedge hclk);
    `CHK(lt_capture_in, 1'b1)
    bus(1'b1, A_CS, 32'h0);
    @(posedge hclk);
    `CHK(wake_osc_en, 1'b0)
    $display("test measure done");
  endtask

  ////////////////////////////////////////////////////////////////////////////////
  task automatic close_out();
    $display("checks_done=%0d n_fail=%0d", checks_done, n_fail);
    if (n_fail == 0 && checks_done > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask
  initial begin
    hclk = 1'b0;
    forever #20 hclk = ~hclk;
  end
  initial begin
    #(40 * 20000);
    n_fail++;
    close_out();
  end
  initial begin
    n_fail = 0;
    checks_done = 0;
    hresetn = 1'b0;
    {hsel, hwrite, halt_cmd, exit_irq, wdg_active} = 5'h0;
    {watchdog_halt_option, stab_long_sel} = 2'h0;
    haddr = 32'h0;
    hwdata = 32'h0;
    htrans = 2'h0;
    hsize = 3'h2;
    repeat (12) @(posedge hclk);
    hresetn <= 1'b1;
    @(posedge hclk);
    t_regs();
    t_wake();
    t_exit();
    t_wdg();
    t_meas();
    close_out();
  end
endmodule
`default_nettype wire
